// ==== src/smbws_defines.svh ====
`ifndef SMBWS_DEFINES_SVH
`define SMBWS_DEFINES_SVH

// core clock rate in kHz
`define SMBWS_CLK_KHZ 20000
// least data hold after a falling scl edge, ns
`define SMBWS_HOLD_NS 300
`define SMBWS_HOLD_CYC ((`SMBWS_HOLD_NS * `SMBWS_CLK_KHZ + 999999) / 1000000)
// wake pulse duration (scl high, sda low), ms
`define SMBWS_WAKE_MS 80
`define SMBWS_WAKE_CYC (`SMBWS_WAKE_MS * `SMBWS_CLK_KHZ)
// serial request time, scl low timeout and scl high timeout, us
`define SMBWS_REQ_US 1500
`define SMBWS_REQ_CYC (`SMBWS_REQ_US * `SMBWS_CLK_KHZ / 1000)
`define SMBWS_TLOW_US 30000
`define SMBWS_TLOW_CYC (`SMBWS_TLOW_US * `SMBWS_CLK_KHZ / 1000)
`define SMBWS_THIGH_US 50
`define SMBWS_THIGH_CYC (`SMBWS_THIGH_US * `SMBWS_CLK_KHZ / 1000)

// command byte decode
`define SMBWS_SPACE_RAM 3'h0
`define SMBWS_SPACE_NVM 3'h1
`define SMBWS_OP_FLAGS 8'hf0
`define SMBWS_OP_SLEEP 8'hff
// crc-8 generator x^8 + x^2 + x + 1
`define SMBWS_CRC_POLY 8'h07

// diagnostic flag word layout
`define SMBWS_FLAG_PEND_BIT 15
`define SMBWS_FLAG_FATAL_BIT 13
`define SMBWS_FLAG_INIT_BIT 12

`endif

// ==== src/smbws_pkg.sv ====
package smbws_pkg;

  // transfer phase of the serial engine
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_ADDR = 3'b001,
    PH_CMD  = 3'b010,
    PH_DLO  = 3'b011,
    PH_DHI  = 3'b100,
    PH_PEC  = 3'b101,
    PH_TX   = 3'b110,
    PH_SKIP = 3'b111
  } smbws_phase_t;

  // temperature source feeding a pulse output slot
  typedef enum logic [1:0] {
    SRC_AMB  = 2'b00,
    SRC_OBJ1 = 2'b01,
    SRC_OBJ2 = 2'b10,
    SRC_NONE = 2'b11
  } smbws_src_t;

endpackage : smbws_pkg

// ==== src/smbws_crc_if.sv ====
`timescale 1ns/1ps
interface smbws_crc_if;
  logic clr;
  logic en;
  logic din;
  logic [7:0] crc;

  modport core (output clr, output en, output din, input crc);
  modport eng (input clr, input en, input din, output crc);
endinterface : smbws_crc_if

// ==== src/smbws_crc.sv ====
`timescale 1ns/1ps
`include "smbws_defines.svh"
module smbws_crc (
  input wire logic core_clk_i, // core clock
  input wire logic sys_rst_i,  // synchronous reset, high
  smbws_crc_if.eng crc_if      // bit stream in, crc out
);

  // one serial crc step, msb first
  function automatic logic [7:0] smbws_crc_step(input logic [7:0] c, input logic d);
    logic fb;
    fb = c[7] ^ d;
    smbws_crc_step = {c[6:0], 1'b0} ^ (fb ? `SMBWS_CRC_POLY : 8'h00);
  endfunction : smbws_crc_step

  // cleared on a fresh start, advanced once per data bit
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || crc_if.clr)
      crc_if.crc <= 8'h00;
    else if (crc_if.en)
      crc_if.crc <= smbws_crc_step(crc_if.crc, crc_if.din);
  end

endmodule : smbws_crc

// ==== src/smbws_top.sv ====
`timescale 1ns/1ps
`include "smbws_defines.svh"
module smbws_top #(
  parameter int WAKE_CYC = `SMBWS_WAKE_CYC,  // wake pulse length in cycles
  parameter int REQ_CYC = `SMBWS_REQ_CYC,    // serial request time in cycles
  parameter int TLOW_CYC = `SMBWS_TLOW_CYC,  // scl low timeout in cycles
  parameter int THIGH_CYC = `SMBWS_THIGH_CYC // scl high timeout in cycles
) (
  input wire logic core_clk_i,          // core clock, 20 MHz
  input wire logic sys_rst_i,           // synchronous reset, high
  input wire logic scl_i,               // bus clock pin
  input wire logic sda_i,               // shared data pin, input side
  output logic sda_o,                   // shared data pin, output level
  output logic sda_oe_o,                // shared data pin, drive enable
  input wire logic [6:0] own_addr_i,    // stored own address
  input wire logic nv_pwm_en_i,         // nonvolatile pulse output enable
  input wire logic nv_push_pull_i,      // push_pull_select bit
  input wire logic [1:0] nv_pwm_fmt_i,  // pulse source select field
  input wire logic pwm_level_i,         // pulse waveform from generator
  output logic pwm_mode_o,              // pin used as pulse output
  output logic pwm_dual_o,              // dual data format
  output smbws_pkg::smbws_src_t pwm_src1_o, // first slot source
  output smbws_pkg::smbws_src_t pwm_src2_o, // second slot source
  output logic mem_rd_o,                // memory read strobe
  output logic mem_wr_o,                // nonvolatile write strobe
  output logic mem_space_o,             // 0 ram, 1 nonvolatile
  output logic [4:0] mem_addr_o,        // word address
  output logic [15:0] mem_wdata_o,      // word to write
  input wire logic [15:0] mem_rdata_i,  // read word, cycle after strobe
  input wire logic nvm_write_pending_i, // nonvolatile write in progress
  input wire logic nvm_fatal_error_i,   // nonvolatile fatal error
  input wire logic init_done_i,         // power-on init finished
  output logic sleep_o,                 // device asleep
  output logic wake_por_o               // wake reset pulse
);

  smbws_crc_if crc_if ();
  smbws_pkg::smbws_phase_t phase;
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  logic start_ev, stop_ev, rise_ev, fall_ev, act, bus_on, comm_rst;
  logic [2:0] hold_cnt;
  logic [31:0] tlow_cnt, thigh_cnt, wake_cnt;
  logic tlow_hit, thigh_hit, req_hit, wake_hit;
  logic [3:0] bcnt;
  logic armed, tx, tx_go, ack_q, drv_low, cmd_ok, sleep_pend, sleep_arm, enter_sleep, rd_pend;
  logic [1:0] tidx;
  logic [6:0] sh;
  logic [7:0] txb, cmd, crc_ref, rx_byte;
  logic [15:0] word, flag_word;
  logic pwm_off, sleeping;

  smbws_crc u_crc (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .crc_if(crc_if)
  );

  // pins are asynchronous to the core clock: two stages, then a third for edges
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
    end
    else
    begin
      {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
    end
  end

  // bus events; sampling on the rising edge only
  assign bus_on = !pwm_mode_o && !sleeping;
  assign start_ev = bus_on && scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_ev = bus_on && scl_s2 && scl_s3 && !sda_s3 && sda_s2;
  assign rise_ev = bus_on && scl_s2 && !scl_s3;
  assign fall_ev = bus_on && !scl_s2 && scl_s3;
  assign rx_byte = {sh, sda_s2};
  assign act = (hold_cnt == 3'h1);
  assign comm_rst = tlow_hit || thigh_hit || wake_hit;
  assign flag_word = {nvm_write_pending_i, 1'b0, nvm_fatal_error_i, init_done_i, 12'h000};

  // data may only move a hold time after scl falls, well inside the low phase
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      hold_cnt <= 3'h0;
    else if (fall_ev)
      hold_cnt <= 3'(`SMBWS_HOLD_CYC);
    else if (hold_cnt != 3'h0)
      hold_cnt <= hold_cnt - 3'h1;
  end

  // scl low and high timers; hits are single-cycle pulses
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || scl_s2)
      tlow_cnt <= 32'h0;
    else if (tlow_cnt != 32'hffffffff)
      tlow_cnt <= tlow_cnt + 32'h1;
    if (sys_rst_i || !scl_s2 || phase == smbws_pkg::PH_IDLE)
      thigh_cnt <= 32'h0;
    else if (thigh_cnt != 32'hffffffff)
      thigh_cnt <= thigh_cnt + 32'h1;
  end
  assign tlow_hit = (tlow_cnt == 32'(TLOW_CYC - 1));
  assign thigh_hit = (thigh_cnt == 32'(THIGH_CYC - 1));
  assign req_hit = pwm_mode_o && (tlow_cnt == 32'(REQ_CYC - 1));

  // wake timer: only runs asleep, with scl high and sda held low
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || !sleeping || !scl_s2 || sda_s2)
      wake_cnt <= 32'h0;
    else if (wake_cnt != 32'hffffffff)
      wake_cnt <= wake_cnt + 32'h1;
  end
  assign wake_hit = sleeping && (wake_cnt == 32'(WAKE_CYC - 1));

  // sleep and pulse disable; a wake acts like a power-on reset
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      sleeping <= 1'b0;
      pwm_off <= 1'b0;
      wake_por_o <= 1'b0;
    end
    else
    begin
      wake_por_o <= wake_hit;
      if (wake_hit)
      begin
        sleeping <= 1'b0;
        pwm_off <= 1'b0;
      end
      else if (enter_sleep)
        sleeping <= 1'b1;
      if (req_hit)
        pwm_off <= 1'b1;
    end
  end
  assign sleep_o = sleeping;

  // pulse mode and source selection, refreshed every cycle
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      pwm_mode_o <= 1'b0;
      pwm_dual_o <= 1'b0;
      pwm_src1_o <= smbws_pkg::SRC_AMB;
      pwm_src2_o <= smbws_pkg::SRC_NONE;
    end
    else
    begin
      pwm_mode_o <= nv_pwm_en_i && !pwm_off && !sleeping && !req_hit;
      case (nv_pwm_fmt_i)
        2'b00:
        begin
          pwm_dual_o <= 1'b1;
          pwm_src1_o <= smbws_pkg::SRC_AMB;
          pwm_src2_o <= smbws_pkg::SRC_OBJ1;
        end
        2'b01:
        begin
          pwm_dual_o <= 1'b0;
          pwm_src1_o <= smbws_pkg::SRC_AMB;
          pwm_src2_o <= smbws_pkg::SRC_NONE;
        end
        2'b11:
        begin
          pwm_dual_o <= 1'b1;
          pwm_src1_o <= smbws_pkg::SRC_OBJ1;
          pwm_src2_o <= smbws_pkg::SRC_OBJ2;
        end
        default:
        begin
          pwm_dual_o <= 1'b0;
          pwm_src1_o <= smbws_pkg::SRC_OBJ2;
          pwm_src2_o <= smbws_pkg::SRC_NONE;
        end
      endcase
    end
  end

  // pin drive: serial mode is always open drain, pulse mode obeys push_pull_select
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end
    else if (pwm_mode_o)
    begin
      sda_o <= pwm_level_i;
      sda_oe_o <= nv_push_pull_i || !pwm_level_i;
    end
    else
    begin
      sda_o <= 1'b0;
      sda_oe_o <= drv_low && bus_on;
    end
  end

  // crc takes each data bit only once scl has fallen after it, so the rise that
  // comes just before a repeated start or a stop never enters the check code
  assign crc_if.clr = start_ev && !cmd_ok;
  assign crc_if.en = act && armed && !bcnt[3] && phase != smbws_pkg::PH_IDLE && phase != smbws_pkg::PH_SKIP;
  assign crc_if.din = sh[0];

  // memory read data returns one cycle after the strobe
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      rd_pend <= 1'b0;
    else
      rd_pend <= mem_rd_o;
  end

  // serial transfer engine
  always_ff @(posedge core_clk_i)
  begin
    mem_rd_o <= 1'b0;
    mem_wr_o <= 1'b0;
    enter_sleep <= 1'b0;
    if (rd_pend)
      word <= mem_rdata_i;
    if (sys_rst_i || comm_rst || !bus_on)
    begin
      phase <= smbws_pkg::PH_IDLE;
      {bcnt, armed, tx, tx_go, ack_q, drv_low, cmd_ok} <= 10'h000;
      {sleep_pend, sleep_arm} <= 2'h0;
      tidx <= 2'h0;
      sh <= 7'h00;
      txb <= 8'h00;
      crc_ref <= 8'h00;
      if (sys_rst_i)
      begin
        cmd <= 8'h00;
        word <= 16'h0000;
        mem_wdata_o <= 16'h0000;
      end
    end
    else if (stop_ev)
    begin
      phase <= smbws_pkg::PH_IDLE;
      {tx, tx_go, ack_q, drv_low, cmd_ok, sleep_pend, sleep_arm} <= 7'h00;
      enter_sleep <= sleep_arm;
    end
    else if (start_ev)
    begin
      // repeated start keeps the command and the running crc
      phase <= smbws_pkg::PH_ADDR;
      {bcnt, armed, tx, tx_go, ack_q, drv_low} <= 9'h000;
      tidx <= 2'h0;
    end
    else if (rise_ev && phase != smbws_pkg::PH_IDLE && phase != smbws_pkg::PH_SKIP)
    begin
      if (bcnt == 4'h8)
      begin
        // master answer to a byte we sent; after the check byte we are done
        if (tx && (sda_s2 || tidx == 2'h2))
        begin
          tx <= 1'b0;
          phase <= smbws_pkg::PH_SKIP;
        end
        else if (tx)
        begin
          tidx <= tidx + 2'h1;
          txb <= (tidx == 2'h0) ? word[15:8] : crc_if.crc;
        end
      end
      else
      begin
        sh <= {sh[5:0], sda_s2};
        if (bcnt == 4'h0)
          crc_ref <= crc_if.crc;
        if (bcnt == 4'h7 && !tx)
        begin
          ack_q <= 1'b0;
          phase <= smbws_pkg::PH_SKIP;
          case (phase)
            smbws_pkg::PH_ADDR:
            begin
              if (!cmd_ok && !rx_byte[0] && (rx_byte[7:1] == own_addr_i || rx_byte[7:1] == 7'h00))
              begin
                ack_q <= 1'b1;
                phase <= smbws_pkg::PH_CMD;
              end
              else if (cmd_ok && rx_byte[0] && rx_byte[7:1] == own_addr_i)
              begin
                ack_q <= 1'b1;
                tx_go <= 1'b1;
                txb <= word[7:0];
                phase <= smbws_pkg::PH_TX;
              end
            end
            smbws_pkg::PH_CMD:
            begin
              cmd <= rx_byte;
              if (rx_byte[7:5] == `SMBWS_SPACE_RAM || rx_byte[7:5] == `SMBWS_SPACE_NVM)
              begin
                ack_q <= 1'b1;
                cmd_ok <= 1'b1;
                mem_rd_o <= 1'b1;
                phase <= smbws_pkg::PH_DLO;
              end
              else if (rx_byte == `SMBWS_OP_FLAGS)
              begin
                ack_q <= 1'b1;
                tx_go <= 1'b1;
                word <= flag_word;
                txb <= flag_word[7:0];
                phase <= smbws_pkg::PH_TX;
              end
              else if (rx_byte == `SMBWS_OP_SLEEP)
              begin
                ack_q <= 1'b1;
                sleep_pend <= 1'b1;
                phase <= smbws_pkg::PH_PEC;
              end
              // any other opcode is refused; it is still stored in cmd but starts no access
            end
            smbws_pkg::PH_DLO:
            begin
              ack_q <= 1'b1;
              mem_wdata_o[7:0] <= rx_byte;
              phase <= smbws_pkg::PH_DHI;
            end
            smbws_pkg::PH_DHI:
            begin
              ack_q <= 1'b1;
              mem_wdata_o[15:8] <= rx_byte;
              phase <= smbws_pkg::PH_PEC;
            end
            smbws_pkg::PH_PEC:
            begin
              // a mismatch is refused and nothing is written
              if (rx_byte == crc_ref)
              begin
                ack_q <= 1'b1;
                sleep_arm <= sleep_pend;
                mem_wr_o <= !sleep_pend && cmd[7:5] == `SMBWS_SPACE_NVM;
              end
            end
            default:
            begin
              ack_q <= 1'b0;
            end
          endcase
        end
      end
    end
    else if (act && phase != smbws_pkg::PH_IDLE)
    begin
      if (!armed)
        armed <= 1'b1;
      else if (bcnt == 4'h7)
      begin
        bcnt <= 4'h8;
        drv_low <= ack_q;
      end
      else if (bcnt == 4'h8)
      begin
        bcnt <= 4'h0;
        ack_q <= 1'b0;
        tx <= tx || tx_go;
        tx_go <= 1'b0;
        drv_low <= (tx || tx_go) && !txb[7];
      end
      else
      begin
        bcnt <= bcnt + 4'h1;
        drv_low <= tx && !txb[3'h6 - bcnt[2:0]];
      end
    end
  end

  assign mem_space_o = cmd[5];
  assign mem_addr_o = cmd[4:0];

endmodule : smbws_top

// ==== sim/smbws_assertions.sv ====
`timescale 1ns/1ps
module smbws_assertions #(
  parameter int REQ_CYC = 30000 // serial request time in cycles
) (
  input wire logic core_clk_i,  // core clock
  input wire logic sys_rst_i,   // synchronous reset, high
  input wire logic scl_i,       // bus clock pin
  input wire logic sda_o,       // data pin level
  input wire logic sda_oe_o,    // data pin drive enable
  input wire logic nv_pwm_en_i, // pulse output enable
  input wire logic pwm_mode_o,  // pin is pulse output
  input wire logic mem_rd_o,    // read strobe
  input wire logic mem_wr_o,    // write strobe
  input wire logic mem_space_o, // memory space
  input wire logic sleep_o,     // asleep
  input wire logic wake_por_o   // wake reset pulse
);
  logic [15:0] low_cnt;
  logic [3:0] since_por;
  // scl low run length, saturating so a long sleep does not wrap
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || scl_i)
      low_cnt <= 16'h0000;
    else if (low_cnt != 16'hffff)
      low_cnt <= low_cnt + 16'h0001;
  end
  // settle time after reset or wake, when pulse mode may still be chosen
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || wake_por_o)
      since_por <= 4'h0;
    else if (since_por != 4'hf)
      since_por <= since_por + 4'h1;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_wake_done;
    !wake_por_o && !sleep_o;
  endsequence
  chk_pwm_after_reset: assert property ($fell(sys_rst_i) |-> ##[0:1] (pwm_mode_o == nv_pwm_en_i))
    else $error("pulse mode does not follow enable after reset");
  chk_request_exit: assert property (low_cnt == 16'(REQ_CYC + 8) |-> !pwm_mode_o)
    else $error("long scl low did not leave pulse mode");
  chk_pwm_stays_off: assert property (since_por == 4'hf && !wake_por_o && !pwm_mode_o |=> !pwm_mode_o)
    else $error("pulse mode came back without wake or reset");
  chk_ack_drives_low: assert property (sda_oe_o && !pwm_mode_o |-> !sda_o)
    else $error("serial mode drives data high");
  chk_change_scl_low: assert property (!pwm_mode_o && !sleep_o && $changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed while scl high");
  chk_wr_nvm_only: assert property (mem_wr_o |-> mem_space_o ##1 !mem_wr_o)
    else $error("write strobe not single or not nonvolatile");
  chk_rd_single: assert property (mem_rd_o |=> !mem_rd_o)
    else $error("read strobe longer than one cycle");
  chk_sleep_quiet: assert property (sleep_o |-> !sda_oe_o && !mem_rd_o && !mem_wr_o)
    else $error("activity while asleep");
  chk_wake_pulse: assert property ($rose(wake_por_o) |-> $past(sleep_o) ##1 s_wake_done)
    else $error("wake pulse without sleep or too long");
endmodule : smbws_assertions

// ==== sim/smbws_host_model.sv ====
`timescale 1ns/1ps
module smbws_host_model (
  input wire logic core_clk_i, // core clock
  input wire logic sda_i,      // resolved data wire
  output logic scl_o,          // bus clock, driven
  output logic sda_low_o       // pulls data low
);
  // idle bus: clock high, data released to the pull-up
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // one 400 ns step of the link grid
  // the link runs faster than the real bus here, matched to the shortened timers
  task tk();
    repeat (8) @(posedge core_clk_i);
  endtask : tk
  // a step of hold after the fall, then data, then the rise
  task bitx(input logic b, output logic r);
    tk();
    sda_low_o <= !b;
    tk();
    scl_o <= 1'b1;
    tk();
    r = sda_i;
    scl_o <= 1'b0;
  endtask : bitx
  task wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask : wbyte
  task rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(nack, r);
  endtask : rbyte
  // serves as start and repeated start
  task start();
    tk();
    sda_low_o <= 1'b0;
    tk();
    scl_o <= 1'b1;
    tk();
    sda_low_o <= 1'b1;
    tk();
    scl_o <= 1'b0;
  endtask : start
  task stop();
    tk();
    sda_low_o <= 1'b1;
    tk();
    scl_o <= 1'b1;
    tk();
    sda_low_o <= 1'b0;
    tk();
  endtask : stop
  // static line levels: request, sleep and wake
  task hold(input logic c, input logic d, input int n);
    scl_o <= c;
    sda_low_o <= !d;
    repeat (n) @(posedge core_clk_i);
  endtask : hold
endmodule : smbws_host_model

// ==== sim/tb_smbws_top.sv ====
`timescale 1ns/1ps
module tb_smbws_top;
  localparam int REQ = 100;
  localparam int WAKE = 200;
  localparam logic [4:0] FX [4] = '{5'h11, 5'h03, 5'h0b, 5'h16};
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic scl, h_low, sda, sda_o, sda_oe, pwm_level = 1'b0;
  logic [6:0] own = 7'h5a;
  logic nv_en = 1'b1, nv_pp = 1'b0, pend = 1'b0, fatal = 1'b0, initd = 1'b1;
  logic [1:0] fmt = 2'b00;
  logic pwm_mode, pwm_dual, mem_rd, mem_wr, mem_space, sleep, wake_por, k1, k2;
  smbws_pkg::smbws_src_t src1, src2;
  logic [4:0] mem_addr, a;
  logic [15:0] mem_wdata, d, mem_rdata = 16'h0000;
  logic [15:0] mem [64];
  logic [21:0] wq [$];
  int miscompares = 0, comparisons = 0, rds = 0, wakes = 0, r0;
  // open-drain wire with pull-up; push-pull only in pulse mode
  assign sda = sda_oe ? (sda_o && !h_low) : !h_low;
  always #25 core_clk_i = ~core_clk_i;
  smbws_top #(.WAKE_CYC(WAKE), .REQ_CYC(REQ), .TLOW_CYC(400), .THIGH_CYC(300)) u_dut (
    .core_clk_i, .sys_rst_i, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_o(sda_oe), .own_addr_i(own),
    .nv_pwm_en_i(nv_en), .nv_push_pull_i(nv_pp), .nv_pwm_fmt_i(fmt), .pwm_level_i(pwm_level),
    .pwm_mode_o(pwm_mode), .pwm_dual_o(pwm_dual), .pwm_src1_o(src1), .pwm_src2_o(src2),
    .mem_rd_o(mem_rd), .mem_wr_o(mem_wr), .mem_space_o(mem_space), .mem_addr_o(mem_addr),
    .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata), .nvm_write_pending_i(pend),
    .nvm_fatal_error_i(fatal), .init_done_i(initd), .sleep_o(sleep), .wake_por_o(wake_por));
  smbws_host_model h (.core_clk_i, .sda_i(sda), .scl_o(scl), .sda_low_o(h_low));
  // memory model: read word ready the cycle after the strobe, writes logged
  always @(posedge core_clk_i)
  begin
    pwm_level <= 1'($urandom);
    if (mem_rd === 1'b1)
    begin
      mem_rdata <= mem[{mem_space, mem_addr}];
      rds++;
    end
    if (mem_wr === 1'b1) wq.push_back({mem_space, mem_addr, mem_wdata});
    if (wake_por === 1'b1) wakes++;
  end
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    c = c ^ b;
    repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction : crc8
  task chk(input logic [23:0] g, input logic [23:0] e, input string m);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // word read, with or without the repeated start
  task rd(input logic [7:0] c, input logic rs, input logic [15:0] e);
    logic [7:0] lo, hi, p, x;
    logic k, k2, k3;
    x = crc8(crc8(8'h00, {own, 1'b0}), c);
    k3 = 1'b1;
    h.start();
    h.wbyte({own, 1'b0}, k);
    h.wbyte(c, k2);
    if (rs)
    begin
      h.start();
      h.wbyte({own, 1'b1}, k3);
      x = crc8(x, {own, 1'b1});
    end
    h.rbyte(1'b0, lo);
    h.rbyte(1'b0, hi);
    h.rbyte(1'b1, p);
    h.stop();
    chk({21'h0, k, k2, k3}, 24'h7, "read acks");
    chk({8'h00, hi, lo}, {8'h00, e}, "word");
    chk({16'h0, p}, {16'h0, crc8(crc8(x, lo), hi)}, "pec");
  endtask : rd
  // write of nb bytes; stops at the first refusal and counts acks
  task wr(input logic [6:0] ad, input logic [7:0] c, input logic [15:0] v, input logic [7:0] f, input int nb,
    input int en);
    logic [7:0] b [5];
    logic [7:0] x;
    logic k;
    int n;
    b = '{{ad, 1'b0}, c, v[7:0], v[15:8], 8'h00};
    x = 8'h00;
    for (int i = 0; i < nb - 1; i++) x = crc8(x, b[i]);
    b[nb - 1] = x ^ f;
    n = 0;
    k = 1'b1;
    h.start();
    for (int i = 0; i < nb && k === 1'b1; i++)
    begin
      h.wbyte(b[i], k);
      if (k === 1'b1) n++;
    end
    h.stop();
    chk(24'(n), 24'(en), "acks");
  endtask : wr
  // hang guard
  initial
  begin
    repeat (100000) @(posedge core_clk_i);
    miscompares++;
    results();
  end
  initial
  begin
    void'($urandom(32'h8e95008a));
    foreach (mem[i]) mem[i] = 16'($urandom);
    a = 5'($urandom);
    d = 16'($urandom);
    repeat (6) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    chk(24'(pwm_mode), 24'h1, "pulse after reset");
    for (int i = 0; i < 4; i++)
    begin
      fmt <= 2'(i);
      repeat (4) @(posedge core_clk_i);
      chk({19'h0, pwm_dual, src1, src2}, 24'(FX[i]), "pulse format");
    end
    h.hold(1'b0, 1'b1, REQ + 20);
    h.hold(1'b1, 1'b1, 40);
    chk(24'(pwm_mode), 24'h0, "serial request");
    rd({3'h0, a}, 1'b1, mem[{1'b0, a}]);
    rd({3'h1, a}, 1'b1, mem[{1'b1, a}]);
    wr(7'h00, {3'h1, a}, 16'h0000, 8'h00, 5, 5);
    wr(own, {3'h1, a}, d, 8'h00, 5, 5);
    wr(own, {3'h1, a}, ~d, 8'h01, 5, 4);
    wr(own, {3'h0, a}, d, 8'h00, 5, 5);
    wr(own ^ 7'h01, {3'h1, a}, d, 8'h00, 5, 0);
    // scl held low past the low timeout: the engine drops the transfer
    h.start();
    h.wbyte({own, 1'b0}, k1);
    h.hold(1'b0, 1'b1, 420);
    h.wbyte({3'h0, a}, k2);
    h.stop();
    chk({22'h0, k1, k2}, 24'h2, "low timeout");
    r0 = rds;
    wr(own, 8'h80, d, 8'h00, 5, 1);
    chk(24'(rds), 24'(r0), "no access");
    chk(24'(wq.size()), 24'h2, "write count");
    chk({2'b0, wq[0]}, {3'h1, a, 16'h0000}, "erase");
    chk({2'b0, wq[1]}, {3'h1, a, d}, "write");
    for (int i = 0; i < 8; i++)
    begin
      {pend, fatal, initd} <= 3'(i);
      rd(8'hf0, 1'b0, {i[2], 1'b0, i[1], i[0], 12'h000});
    end
    wr(own, 8'hff, 16'h0000, 8'h00, 3, 3);
    chk(24'(sleep), 24'h1, "sleep");
    nv_pp <= 1'b1;
    h.hold(1'b0, 1'b1, 500);
    h.hold(1'b1, 1'b1, 16);
    h.hold(1'b1, 1'b0, WAKE + 20);
    h.hold(1'b1, 1'b1, 20);
    chk(24'(wakes), 24'h1, "wake pulse");
    chk({23'h0, pwm_mode}, 24'h1, "pulse after wake");
    results();
  end
endmodule : tb_smbws_top
bind smbws_top smbws_assertions #(.REQ_CYC(REQ_CYC)) u_chk (.core_clk_i, .sys_rst_i, .scl_i, .sda_o,
  .sda_oe_o, .nv_pwm_en_i, .pwm_mode_o, .mem_rd_o, .mem_wr_o, .mem_space_o, .sleep_o, .wake_por_o);
